// ===== hdl/coh_route_pkg.sv
// Shared constants and types for the coherency routing unit and its outside partner.
package coh_route_pkg;
	// Register byte offsets on the control bus.
	localparam logic [7:0] ctrl_off   = 8'h00;
	localparam logic [7:0] start_off  = 8'h04;
	localparam logic [7:0] end_off    = 8'h08;
	localparam logic [7:0] status_off = 8'h0c;
	// Control register fields.
	localparam int ctrl_filter_bit = 1;
	localparam int ctrl_force_bit  = 2;
	localparam logic [31:0] ctrl_reset  = 32'h0000_0000;
	localparam logic [31:0] start_reset = 32'h0000_0000;
	localparam logic [31:0] end_reset   = 32'h0000_0000;
	// Coherency qualifier positions in user and cache attributes.
	localparam int user_shared_bit = 0;
	localparam int cache_alloc_bit = 1;
	// Forwarded slave-port identifier layout.
	localparam logic       id_from_slave = 1'b1;
	localparam logic [1:0] id_low_forced = 2'b00;
	// Address bit that interleaves unfiltered traffic between the two master ports.
	localparam int interleave_bit = 5;
	// Default bus-to-core ratios: the master one in half core cycles, the slave one in whole core cycles.
	localparam int master_ratio_half = 3;
	localparam int slave_ratio       = 2;
	typedef logic [31:0] addr_t;
	typedef logic [63:0] data_t;
	typedef logic [5:0]  mid_t;
endpackage

// ===== hdl/coh_link_if.sv
// Link between the coherency routing unit and the outside interconnect and accelerator.
interface coh_link_if;
	import coh_route_pkg::*;
	logic        port0_input_qualifier;
	logic        port0_output_qualifier;
	logic        port1_input_qualifier;
	logic        port1_output_qualifier;
	logic        slave_port_clock_enable;
	logic        acp_valid;
	logic        acp_ready;
	logic        acp_write;
	addr_t       acp_addr;
	logic [3:0]  acp_cache;
	logic [4:0]  acp_user;
	logic        acp_lock;
	logic [2:0]  acp_id;
	data_t       acp_wdata;
	logic        acp_rvalid;
	data_t       acp_rdata;
	logic [1:0]  mst_valid;
	logic [1:0]  mst_ready;
	logic        mst_write;
	addr_t       mst_addr;
	logic [3:0]  mst_cache;
	logic        mst_lock;
	mid_t        mst_id;
	data_t       mst_wdata;
	logic        external_event_in;
	logic        external_event_out;
	modport dev (
		input  port0_input_qualifier, port0_output_qualifier, port1_input_qualifier, port1_output_qualifier,
		input  slave_port_clock_enable, acp_valid, acp_write, acp_addr, acp_cache, acp_user, acp_lock,
		input  acp_id, acp_wdata, mst_ready, external_event_in,
		output acp_ready, acp_rvalid, acp_rdata, mst_valid, mst_write, mst_addr, mst_cache, mst_lock,
		output mst_id, mst_wdata, external_event_out
	);
	modport ext (
		output port0_input_qualifier, port0_output_qualifier, port1_input_qualifier, port1_output_qualifier,
		output slave_port_clock_enable, acp_valid, acp_write, acp_addr, acp_cache, acp_user, acp_lock,
		output acp_id, acp_wdata, mst_ready, external_event_in,
		input  acp_ready, acp_rvalid, acp_rdata, mst_valid, mst_write, mst_addr, mst_cache, mst_lock,
		input  mst_id, mst_wdata, external_event_out
	);
endinterface

// ===== hdl/ratio_enable_gen.sv
// Clock-enable generator for whole and half-step bus-to-core ratios.
module ratio_enable_gen #(
	parameter int ratio_half = 2
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      enable_q
);
	localparam logic [7:0] step = 8'h02;
	localparam logic [7:0] lim  = 8'(ratio_half);

	// Only ratios from 1 up to 63.5 in half steps are served.
	initial
	begin
		if (ratio_half < 2 || ratio_half > 127)
			$error("ratio_half out of range");
	end

	logic [7:0] acc_q;

	// Each core cycle adds two half steps; a bus edge falls where the sum wraps.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_q    <= 8'h00;
			enable_q <= 1'b0;
		end
		else if (acc_q + step >= lim)
		begin
			acc_q    <= acc_q + step - lim;
			enable_q <= 1'b1;
		end
		else
		begin
			acc_q    <= acc_q + step;
			enable_q <= 1'b0;
		end
	end
endmodule

// ===== hdl/coh_route_dev.sv
// Coherency unit request router: address filter, slave-port coherency and event pins.
module coh_route_dev
	import coh_route_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 filter_enable_strap,
	input  wire coh_route_pkg::addr_t filter_window_start_strap,
	input  wire coh_route_pkg::addr_t filter_window_end_strap,
	input  wire logic                 core_req_valid,
	output logic                      core_req_ready,
	input  wire logic                 core_req_write,
	input  wire coh_route_pkg::addr_t core_req_addr,
	input  wire logic [3:0]           core_req_cache,
	input  wire logic                 core_req_device,
	input  wire logic                 core_req_lock,
	input  wire logic [1:0]           core_req_cpu,
	input  wire coh_route_pkg::data_t core_req_wdata,
	input  wire logic                 line_held,
	input  wire coh_route_pkg::data_t line_data,
	output logic                      clean_invalidate_req,
	input  wire logic                 clean_invalidate_done,
	input  wire logic                 send_event_instruction,
	output logic                      core_event,
	coh_link_if.dev                   link
);
	import coh_route_pkg::*;

	typedef enum {st_idle, st_clean, st_reply, st_issue} eng_e;

	eng_e       state_q;
	logic [31:0] ctrl_q;
	addr_t      start_q;
	addr_t      end_q;
	logic       strap_done_q;
	logic       req_write_q;
	addr_t      req_addr_q;
	logic [3:0] req_cache_q;
	logic       req_lock_q;
	logic       req_device_q;
	mid_t       req_id_q;
	data_t      req_wdata_q;
	logic       req_port_q;
	logic       event_in_d1_q;
	logic       route_port;
	logic       acp_take;
	logic       acp_coherent;
	logic       port_in_qual;
	logic       port_out_qual;

	assign acp_take = link.acp_valid && link.acp_ready && link.slave_port_clock_enable;
	assign acp_coherent = link.acp_user[user_shared_bit] && link.acp_cache[cache_alloc_bit];
	assign port_in_qual  = req_port_q ? link.port1_input_qualifier : link.port0_input_qualifier;
	assign port_out_qual = req_port_q ? link.port1_output_qualifier : link.port0_output_qualifier;

	// Port choice for the request held in the engine; same address picks the same port except that unfiltered
	// locked and forced device requests take port 0, so other unfiltered traffic keeps its ordering without tracking outstanding transfers.
	always_comb
	begin
		if (ctrl_q[ctrl_filter_bit])
			route_port = (req_addr_q >= start_q) && (req_addr_q <= end_q);
		else if (req_lock_q)
			route_port = 1'b0;
		else if (ctrl_q[ctrl_force_bit] && req_device_q)
			route_port = 1'b0;
		else
			route_port = req_addr_q[interleave_bit];
	end

	// Control bus slave with no wait states; unmapped offsets answer with an error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (paddr > status_off || paddr[1:0] != 2'b00);
			unique case (paddr)
				ctrl_off:   prdata <= ctrl_q;
				start_off:  prdata <= start_q;
				end_off:    prdata <= end_q;
				status_off: prdata <= {29'h0, link.mst_valid, state_q != st_idle};
				default:    prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Filter registers: straps are caught on the first edge after reset release, writes later.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_done_q <= 1'b0;
			ctrl_q       <= ctrl_reset;
			start_q      <= start_reset;
			end_q        <= end_reset;
		end
		else if (!strap_done_q)
		begin
			strap_done_q             <= 1'b1;
			ctrl_q[ctrl_filter_bit]  <= filter_enable_strap;
			start_q                  <= filter_window_start_strap;
			end_q                    <= filter_window_end_strap;
		end
		else if (psel && penable && pready && pwrite)
		begin
			if (paddr == ctrl_off)
				ctrl_q <= pwdata;
			if (paddr == start_off)
				start_q <= pwdata;
			if (paddr == end_off)
				end_q <= pwdata;
		end
	end

	// Request engine. Slave-port requests win over core requests because the accelerator
	// has no retry path; the core side simply waits on its ready.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q              <= st_idle;
			req_write_q          <= 1'b0;
			req_addr_q           <= 32'h0000_0000;
			req_cache_q          <= 4'h0;
			req_lock_q           <= 1'b0;
			req_device_q         <= 1'b0;
			req_id_q             <= 6'h00;
			req_wdata_q          <= 64'h0;
			clean_invalidate_req <= 1'b0;
		end
		else
		begin
			clean_invalidate_req <= 1'b0;
			unique case (state_q)
				st_idle:
				begin
					if (acp_take)
					begin
						req_write_q  <= link.acp_write;
						req_addr_q   <= link.acp_addr;
						req_cache_q  <= link.acp_cache;
						req_device_q <= 1'b0;
						req_wdata_q  <= link.acp_wdata;
						req_id_q     <= {link.acp_id, id_from_slave, id_low_forced};
						req_lock_q   <= acp_coherent ? 1'b0 : link.acp_lock;
						if (acp_coherent && line_held && !link.acp_write)
							state_q <= st_reply;
						else if (acp_coherent && line_held)
						begin
							clean_invalidate_req <= 1'b1;
							state_q              <= st_clean;
						end
						else
							state_q <= st_issue;
					end
					else if (core_req_valid && core_req_ready)
					begin
						req_write_q  <= core_req_write;
						req_addr_q   <= core_req_addr;
						req_cache_q  <= core_req_cache;
						req_device_q <= core_req_device;
						req_lock_q   <= core_req_lock;
						req_wdata_q  <= core_req_wdata;
						req_id_q     <= {3'b000, 1'b0, core_req_cpu};
						state_q      <= st_issue;
					end
				end
				st_clean:
				begin
					if (clean_invalidate_done)
						state_q <= st_issue;
				end
				st_reply:
				begin
					if (link.slave_port_clock_enable)
						state_q <= st_idle;
				end
				st_issue:
				begin
					if (link.mst_valid[req_port_q] && port_in_qual && link.mst_ready[req_port_q])
						state_q <= st_idle;
				end
			endcase
		end
	end

	// Master port drive: requests launch on the chosen port's output qualifier edge and retire on its input qualifier.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_port_q     <= 1'b0;
			link.mst_valid <= 2'b00;
			link.mst_write <= 1'b0;
			link.mst_addr  <= 32'h0000_0000;
			link.mst_cache <= 4'h0;
			link.mst_lock  <= 1'b0;
			link.mst_id    <= 6'h00;
			link.mst_wdata <= 64'h0;
		end
		// Re-route until the held choice matches the request just loaded; a choice left over from
		// the previous address would launch on the wrong port and its qualifier.
		else if (state_q != st_issue || (link.mst_valid == 2'b00 && req_port_q != route_port))
			req_port_q <= route_port;
		else if (port_out_qual && link.mst_valid == 2'b00)
		begin
			link.mst_valid[req_port_q] <= 1'b1;
			link.mst_write             <= req_write_q;
			link.mst_addr              <= req_addr_q;
			link.mst_cache             <= req_cache_q;
			link.mst_lock              <= req_lock_q;
			link.mst_id                <= req_id_q;
			link.mst_wdata             <= req_wdata_q;
		end
		else if (port_in_qual && link.mst_ready[req_port_q] && link.mst_valid[req_port_q])
			link.mst_valid <= 2'b00;
	end

	// Slave-port handshakes and reply data; every slave-side output moves only on its enable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.acp_ready <= 1'b0;
			link.acp_rvalid <= 1'b0;
			link.acp_rdata <= 64'h0;
			core_req_ready <= 1'b0;
		end
		else
		begin
			core_req_ready <= 1'b0;
			if (link.slave_port_clock_enable)
			begin
				link.acp_ready  <= state_q == st_idle && !acp_take && !link.acp_ready;
				link.acp_rvalid <= state_q == st_reply;
				link.acp_rdata  <= line_data;
			end
			if (state_q == st_idle && !link.acp_valid && !core_req_ready)
				core_req_ready <= 1'b1;
		end
	end

	// Event pins: a send event is registered out for as many cycles as it is held, a rising input wakes every core.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_in_d1_q           <= 1'b0;
			core_event              <= 1'b0;
			link.external_event_out <= 1'b0;
		end
		else
		begin
			event_in_d1_q <= link.external_event_in;
			core_event <= link.external_event_in && !event_in_d1_q;
			link.external_event_out <= send_event_instruction;
		end
	end
endmodule

// ===== hdl/coh_route_ext.sv
// Outside partner: accelerator master, interconnect sink and clock-enable source.
module coh_route_ext
	import coh_route_pkg::*;
#(
	parameter int m0_ratio_half = master_ratio_half,
	parameter int m1_ratio_half = master_ratio_half,
	parameter int s_ratio       = slave_ratio
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire logic                 cmd_write,
	input  wire coh_route_pkg::addr_t cmd_addr,
	input  wire logic [3:0]           cmd_cache,
	input  wire logic [4:0]           cmd_user,
	input  wire logic                 cmd_lock,
	input  wire logic [2:0]           cmd_id,
	input  wire coh_route_pkg::data_t cmd_wdata,
	output logic                      reply_valid,
	output coh_route_pkg::data_t      reply_data,
	output logic [1:0]                sink_seen,
	output coh_route_pkg::mid_t       sink_id,
	input  wire logic                 agent_event,
	output logic                      agent_event_seen,
	coh_link_if.ext                   link
);
	import coh_route_pkg::*;

	initial
	begin
		if (s_ratio < 1 || s_ratio > 63)
			$error("s_ratio must be a whole number from 1 to 63");
	end

	logic e0;
	logic e1;
	logic es;

	ratio_enable_gen #(.ratio_half(m0_ratio_half)) gen0 (.pclk(pclk), .presetn(presetn), .enable_q(e0));
	ratio_enable_gen #(.ratio_half(m1_ratio_half)) gen1 (.pclk(pclk), .presetn(presetn), .enable_q(e1));
	ratio_enable_gen #(.ratio_half(2 * s_ratio))   gens (.pclk(pclk), .presetn(presetn), .enable_q(es));

	assign link.port0_input_qualifier   = e0;
	assign link.port0_output_qualifier  = e0;
	assign link.port1_input_qualifier   = e1;
	assign link.port1_output_qualifier  = e1;
	assign link.slave_port_clock_enable = es;

	// Accelerator request: loaded from the user port, held until taken on an enable edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.acp_valid <= 1'b0;
			link.acp_write <= 1'b0;
			link.acp_addr  <= 32'h0000_0000;
			link.acp_cache <= 4'h0;
			link.acp_user  <= 5'h00;
			link.acp_lock  <= 1'b0;
			link.acp_id    <= 3'h0;
			link.acp_wdata <= 64'h0;
			cmd_ready      <= 1'b0;
		end
		else
		begin
			cmd_ready <= 1'b0;
			if (link.acp_valid && link.acp_ready && es)
				link.acp_valid <= 1'b0;
			else if (!link.acp_valid && cmd_valid && !cmd_ready)
			begin
				link.acp_valid <= 1'b1;
				link.acp_write <= cmd_write;
				link.acp_addr  <= cmd_addr;
				link.acp_cache <= cmd_cache;
				link.acp_user  <= cmd_user;
				link.acp_lock  <= cmd_lock;
				link.acp_id    <= cmd_id;
				link.acp_wdata <= cmd_wdata;
				cmd_ready      <= 1'b1;
			end
		end
	end

	// Interconnect sink: always ready, reports each transfer taken on its input qualifier.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.mst_ready   <= 2'b00;
			sink_seen        <= 2'b00;
			sink_id          <= 6'h00;
			reply_valid      <= 1'b0;
			reply_data       <= 64'h0;
		end
		else
		begin
			link.mst_ready <= 2'b11;
			sink_seen      <= link.mst_valid & link.mst_ready & {e1, e0};
			if (|(link.mst_valid & {e1, e0}))
				sink_id <= link.mst_id;
			reply_valid <= link.acp_rvalid && es;
			if (link.acp_rvalid && es)
				reply_data <= link.acp_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.external_event_in <= 1'b0;
			agent_event_seen       <= 1'b0;
		end
		else
		begin
			link.external_event_in <= agent_event;
			agent_event_seen       <= link.external_event_out;
		end
	end
endmodule

// ===== sim/coh_route_props.sv
// Concurrent checks on the link between the routing unit and its outside partner.
module coh_route_props
	import coh_route_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                port0_input_qualifier,
	input wire logic                port0_output_qualifier,
	input wire logic                port1_input_qualifier,
	input wire logic                port1_output_qualifier,
	input wire logic                slave_port_clock_enable,
	input wire logic                acp_valid,
	input wire logic                acp_ready,
	input wire logic                acp_rvalid,
	input wire logic [1:0]          mst_valid,
	input wire logic [1:0]          mst_ready,
	input wire coh_route_pkg::mid_t mst_id,
	input wire logic                external_event_out
);
	// One clock domain, so every check shares its clock and sleeps in reset.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// The slave port only moves on enabled edges, and a take retires ready at once.
	a_ready_on_enable: assert property (!$stable(acp_ready) |-> $past(slave_port_clock_enable))
		else $error("slave ready moved off an enabled edge");
	a_rvalid_on_enable: assert property ($rose(acp_rvalid) |-> $past(slave_port_clock_enable))
		else $error("slave reply rose off an enabled edge");
	a_take_drops_ready: assert property (acp_valid && acp_ready && slave_port_clock_enable |=> !acp_ready)
		else $error("slave ready held after a take");

	// A master request starts on its output qualifier and retires after a qualified handshake.
	a_p0_start_qual: assert property ($rose(mst_valid[0]) |-> $past(port0_output_qualifier))
		else $error("port 0 request rose off its qualifier");
	a_p1_start_qual: assert property ($rose(mst_valid[1]) |-> $past(port1_output_qualifier))
		else $error("port 1 request rose off its qualifier");
	a_p0_retire: assert property (mst_valid[0] && mst_ready[0] && port0_input_qualifier |=> !mst_valid[0])
		else $error("port 0 request held after handshake");
	a_p1_retire: assert property (mst_valid[1] && mst_ready[1] && port1_input_qualifier |=> !mst_valid[1])
		else $error("port 1 request held after handshake");

	// Forwarded slave identifiers keep the low pair cleared.
	a_slave_id_low: assert property (mst_valid != 2'b00 && mst_id[2] == id_from_slave
		|-> mst_id[1:0] == id_low_forced)
		else $error("forwarded identifier low bits not cleared");

	// The bench never sends two events back to back, so each output pulse is one cycle.
	a_event_single: assert property ($rose(external_event_out) |=> $fell(external_event_out))
		else $error("event output longer than one cycle");
endmodule

// ===== sim/coherency_port_routing_tb.sv
// Self-checking bench joining the routing unit to its outside partner through the link.
module coherency_port_routing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import coh_route_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, core_req_ready, clean_invalidate_req, core_event, cmd_ready, reply_valid;
	logic        agent_event_seen, filter_enable_strap = 1'b1, core_req_valid = 1'b0, core_req_write = 1'b0;
	logic        core_req_device = 1'b0, core_req_lock = 1'b0, line_held = 1'b0, clean_invalidate_done = 1'b0;
	logic        send_event_instruction = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_lock = 1'b0;
	logic        agent_event = 1'b0, fen_m, force_m;
	logic [1:0]  core_req_cpu = 2'h0, sink_seen;
	logic [2:0]  cmd_id = 3'h0;
	logic [3:0]  core_req_cache = 4'h0, cmd_cache = 4'h0;
	logic [4:0]  cmd_user = 5'h00;
	addr_t       filter_window_start_strap = 32'h0000_3000, filter_window_end_strap = 32'h0000_30ff;
	addr_t       core_req_addr = 32'h0, cmd_addr = 32'h0, st_m, en_m;
	data_t       core_req_wdata = 64'h0, cmd_wdata = 64'h0, line_data = 64'h0, reply_data;
	mid_t        sink_id;
	int          seed, n_fail = 0, num_checks = 0, n_clean = 0, cyc = 0;

	coh_link_if link_if ();
	// Port 1 runs at the half-step ratio 2.5 and the slave port at the whole ratio 3.
	coh_route_ext #(.m0_ratio_half(3), .m1_ratio_half(5), .s_ratio(3)) coh_route_ext_inst (.pclk, .presetn,
		.cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_cache, .cmd_user, .cmd_lock, .cmd_id, .cmd_wdata,
		.reply_valid, .reply_data, .sink_seen, .sink_id, .agent_event, .agent_event_seen, .link(link_if));
	coh_route_dev coh_route_dev_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .filter_enable_strap, .filter_window_start_strap, .filter_window_end_strap, .core_req_valid,
		.core_req_ready, .core_req_write, .core_req_addr, .core_req_cache, .core_req_device, .core_req_lock,
		.core_req_cpu, .core_req_wdata, .line_held, .line_data, .clean_invalidate_req, .clean_invalidate_done,
		.send_event_instruction, .core_event, .link(link_if));
	coh_route_props coh_route_props_inst (.pclk, .presetn,
		.port0_input_qualifier(link_if.port0_input_qualifier), .port0_output_qualifier(link_if.port0_output_qualifier),
		.port1_input_qualifier(link_if.port1_input_qualifier), .port1_output_qualifier(link_if.port1_output_qualifier),
		.slave_port_clock_enable(link_if.slave_port_clock_enable), .acp_valid(link_if.acp_valid),
		.acp_ready(link_if.acp_ready), .acp_rvalid(link_if.acp_rvalid), .mst_valid(link_if.mst_valid),
		.mst_ready(link_if.mst_ready), .mst_id(link_if.mst_id), .external_event_out(link_if.external_event_out));

	always #5 pclk = ~pclk;

	// Answer each clean request a cycle later, count them, and cut a hang short.
	always @(posedge pclk)
	begin
		clean_invalidate_done <= clean_invalidate_req;
		n_clean <= n_clean + int'(clean_invalidate_req === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Reference routing: the window wins over everything, else lock and forced devices stay on port 0.
	function automatic logic route(input addr_t a, input logic lk, input logic dv);
		if (fen_m)
			return a >= st_m && a <= en_m;
		if (lk || (force_m && dv))
			return 1'b0;
		return a[interleave_bit];
	endfunction

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits up to 400 cycles for a slave reply or a master-side arrival, then checks the one seen is the one the request should produce.
	task automatic expect_out(input logic rep, input logic p, input mid_t id, input data_t d, input addr_t a,
		input logic lk);
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (reply_valid !== 1'b1 && sink_seen === 2'b00 && n < 400);
		chk("reply", 64'(rep), 64'(reply_valid));
		if (rep)
			chk("reply data", d, reply_data);
		else
		begin
			chk("master port", 64'(p ? 2'b10 : 2'b01), 64'(sink_seen));
			chk("master id", 64'(id), 64'(sink_id));
			chk("master addr", 64'(a), 64'(link_if.mst_addr));
			chk("master lock", 64'(lk), 64'(link_if.mst_lock));
		end
	endtask

	task automatic core_go(input addr_t a, input logic dv, input logic lk, input logic [1:0] cpu);
		@(posedge pclk);
		core_req_valid <= 1'b1;
		core_req_addr <= a;
		core_req_device <= dv;
		core_req_lock <= lk;
		core_req_cpu <= cpu;
		core_req_write <= a[0];
		do @(posedge pclk); while (core_req_ready !== 1'b1);
		core_req_valid <= 1'b0;
		expect_out(1'b0, route(a, lk, dv), {4'b0000, cpu}, 64'h0, a, lk);
	endtask

	// Coherent requests lose their lock, so they route as unlocked.
	task automatic slave_go(input logic w, input logic su, input logic sc, input logic hd, input logic lk);
		logic [4:0] u;
		logic [3:0] c;
		logic [2:0] idv;
		addr_t      a;
		data_t      ld;
		int         c0;
		u = {4'($random(seed)), su};
		c = 4'($random(seed));
		c[cache_alloc_bit] = sc;
		idv = 3'($random(seed));
		a = $random(seed);
		a[4:0] = 5'h00;
		ld = {$random(seed), $random(seed)};
		c0 = n_clean;
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_cache <= c;
		cmd_user <= u;
		cmd_lock <= lk;
		cmd_id <= idv;
		cmd_wdata <= ld;
		line_held <= hd;
		line_data <= ld;
		do @(posedge pclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		expect_out(!w && su && sc && hd, route(a, lk && !(su && sc), 1'b0), {idv, id_from_slave, id_low_forced}, ld,
			a, lk && !(su && sc));
		chk("clean requests", 64'(w && su && sc && hd), 64'(n_clean - c0));
	endtask

	task automatic ev_go();
		int sc;
		int so;
		sc = 0;
		so = 0;
		@(posedge pclk);
		send_event_instruction <= 1'b1;
		agent_event <= 1'b1;
		@(posedge pclk);
		send_event_instruction <= 1'b0;
		agent_event <= 1'b0;
		repeat (12)
		begin
			@(posedge pclk);
			sc += int'(core_event === 1'b1);
			so += int'(agent_event_seen === 1'b1);
		end
		chk("core event pulses", 64'h1, 64'(sc));
		chk("event out pulses", 64'h1, 64'(so));
	endtask

	// Main sequence: strapped registers, filtered edges, unfiltered traffic, slave coherency, events.
	initial
	begin
		logic [31:0] q;
		logic        e;
		seed = 49;
		fen_m = 1'b1;
		force_m = 1'b0;
		st_m = filter_window_start_strap;
		en_m = filter_window_end_strap;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, ctrl_off, 32'h0, q, e);
		chk("control", 64'(1 << ctrl_filter_bit), 64'(q));
		apb(1'b0, start_off, 32'h0, q, e);
		chk("start", 64'(st_m), 64'(q));
		apb(1'b0, end_off, 32'h0, q, e);
		chk("end", 64'(en_m), 64'(q));
		apb(1'b1, 8'h10, 32'hffff_ffff, q, e);
		chk("unmapped error", 64'h1, 64'(e));
		apb(1'b0, status_off, 32'h0, q, e);
		chk("status", 64'h0, 64'(q));
		apb(1'b1, ctrl_off, 32'h6, q, e);
		force_m = 1'b1;
		for (int k = 0; k < 4; k++)
			core_go(k < 2 ? st_m - 32'(k == 0) : en_m + 32'(k == 3), 1'b1, k[0], 2'(k));
		apb(1'b1, ctrl_off, 32'h0, q, e);
		fen_m = 1'b0;
		force_m = 1'b0;
		for (int k = 0; k < 16; k++)
		begin
			if (k == 8)
			begin
				apb(1'b1, ctrl_off, 32'(1 << ctrl_force_bit), q, e);
				force_m = 1'b1;
			end
			core_go($random(seed), 1'($random(seed)), 1'($random(seed)), 2'($random(seed)));
		end
		for (int k = 0; k < 8; k++)
			slave_go(k[2], k[1:0] != 2'd2, k[1:0] != 2'd3, k[1:0] != 2'd1, k[1]);
		apb(1'b1, start_off, 32'h0000_5a00, q, e);
		apb(1'b0, start_off, 32'h0, q, e);
		chk("start rewritten", 64'h5a00, 64'(q));
		repeat (2) ev_go();
		conclude();
	end
endmodule
